// ==== inc/asp_params.svh ====
// Constants for the converter serial pin interface
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_CMD_BITS 4'h8
`define ASP_RST_ONES 6'h20
`define ASP_RS_HI 5
`define ASP_RS_LO 4
`define ASP_RW_BIT 3
`define ASP_CREAD_BIT 2
`define ASP_RS_COMM 2'h0
`define ASP_RS_STATUS 2'h0
`define ASP_RS_MODE 2'h1
`define ASP_RS_DATA 2'h3
`define ASP_RS_AUX 2'h2
`define ASP_STATUS_RDY_BIT 7
`define ASP_STATUS_RESET 8'h88
`define ASP_MODE_RESET 8'h02
`define ASP_AUX_RESET 8'h00
`define ASP_DATA_BITS 6'h18
`define ASP_BYTE_BITS 6'h08
`define ASP_REG_COUNT 4
`endif

// ==== inc/asp_pkg.sv ====
// Types for the converter serial pin interface
`default_nettype none
package asp_pkg;
    typedef enum logic [2:0] {
        ASP_CMD  = 3'h1,
        ASP_WR   = 3'h2,
        ASP_RD   = 3'h4
    } asp_state_t;
endpackage : asp_pkg
`default_nettype wire

// ==== rtl/asp_reg_mem.sv ====
// Small register store for the words written over the serial port
`default_nettype none
`include "asp_params.svh"
module asp_reg_mem
    import asp_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Write port
    input wire logic i_wr_en,
    input wire logic [1:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    // Read port
    input wire logic [1:0] i_rd_addr,
    output logic [7:0] o_rd_data
);
    logic [7:0] mem_reg [`ASP_REG_COUNT];

    genvar g;
    generate
        for (g = 0; g < `ASP_REG_COUNT; g++) begin : g_word
            always_ff @(posedge i_clk) begin
                if (!i_reset_n) begin
                    mem_reg[g] <= (g == `ASP_RS_MODE) ? `ASP_MODE_RESET : `ASP_AUX_RESET;
                end else if (i_wr_en && i_wr_addr == 2'(g)) begin
                    mem_reg[g] <= i_wr_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= mem_reg[i_rd_addr];
        end
    end
endmodule : asp_reg_mem
`default_nettype wire

// ==== rtl/asp_serial_port.sv ====
// Serial pin interface of a sigma-delta converter, device side
// How it works
// - The serial clock is sampled and edge-detected, so bursts or a free clock work alike.
// - Select is active low and gates shifting and output drive.
// - With select tied low the port runs on clock, data in and data out alone.
// - The data-out/ready line falls when a new conversion result is posted.
// - Output bits after the first change after a clock falling edge and are captured by the host on rising.
// - The status register carries a ready flag that tracks the same event.
// - When deselected the data-out line is released but the ready flag keeps updating.
// - Input bits shift into a register and land in the register chosen by the command, unless that is the data register.
// - Each access starts with an 8-bit command word and returns to waiting for one after.
// - Thirty-two clocks with data in high reset the whole port.
// - Ready goes back high once the host has read the result.
// - A leading one on the command word holds the bit position until a zero arrives.
`default_nettype none
`include "asp_params.svh"
module asp_serial_port
    import asp_pkg::*;
(
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // Serial pins
    input wire logic I_SCLK,
    input wire logic I_SEL_N,
    input wire logic I_SDI,
    output logic O_SDO_RDY_N,
    output logic O_SDO_RDY_OE,
    // Conversion side
    input wire logic I_CONV_VALID,
    input wire logic [23:0] I_CONV_DATA,
    output logic O_STATUS_RDY
);
    // Two-stage synchronisers for the pins
    logic [2:0] sclk_meta_reg, sclk_sync_reg;
    logic sclk_prev_reg;
    logic [2:0] pins_sync;
    asp_state_t state_reg, state_next;
    logic [23:0] shift_reg, out_reg;
    logic [5:0] count_reg, ones_reg;
    logic [1:0] rs_reg;
    logic cread_reg, rdy_reg, data_reg, oe_reg;
    logic [23:0] latched_reg;
    logic [7:0] mem_rd;
    logic sclk_rise, sclk_fall, selected, cmd_done, wr_done, rd_done, soft_rst;
    logic [5:0] access_len;
    logic [7:0] status_word;
    logic [1:0] cmd_rs;

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            sclk_meta_reg <= 3'h7;
            sclk_sync_reg <= 3'h7;
        end else begin
            sclk_meta_reg <= {I_SCLK, I_SEL_N, I_SDI};
            sclk_sync_reg <= sclk_meta_reg;
        end
    end
    assign pins_sync = sclk_sync_reg;

    // Edge detection on the synchronised clock
    assign sclk_rise = pins_sync[2] && !sclk_prev_reg;
    assign sclk_fall = !pins_sync[2] && sclk_prev_reg;
    assign selected = !pins_sync[1];

    function automatic logic [5:0] len_of(input logic [1:0] rs);
        len_of = (rs == `ASP_RS_DATA) ? `ASP_DATA_BITS : `ASP_BYTE_BITS;
    endfunction : len_of

    assign access_len = len_of(rs_reg);
    // Fixed status bits are the reset pattern below the ready bit
    assign status_word = {~rdy_reg, 7'(`ASP_STATUS_RESET)};
    // Select field of the command being shifted in, settled well before its last bit
    assign cmd_rs = shift_reg[`ASP_RS_HI - 1:`ASP_RS_LO - 1];
    assign soft_rst = sclk_rise && selected && pins_sync[0]
        && ones_reg == `ASP_RST_ONES - 6'h01;
    // Command bit 7 must be zero before the field is loaded
    assign cmd_done = state_reg == ASP_CMD && sclk_rise && selected && !soft_rst
        && count_reg == `ASP_CMD_BITS - 6'h01 && !(count_reg == 6'h00 && pins_sync[0]);
    assign wr_done = state_reg == ASP_WR && sclk_rise && selected
        && count_reg == access_len - 6'h01;
    assign rd_done = state_reg == ASP_RD && sclk_rise && selected
        && count_reg == access_len - 6'h01;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ASP_CMD: begin
                if (cmd_done) begin
                    state_next = shift_reg[`ASP_RW_BIT - 1] ? ASP_RD : ASP_WR;
                end
            end
            ASP_WR: begin
                if (wr_done) begin
                    state_next = ASP_CMD;
                end
            end
            ASP_RD: begin
                if (rd_done) begin
                    state_next = ASP_CMD;
                end
            end
            default: state_next = ASP_CMD;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N || soft_rst) begin
            state_reg <= ASP_CMD;
            count_reg <= 6'h00;
            shift_reg <= 24'h000000;
            rs_reg <= `ASP_RS_COMM;
            cread_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (sclk_rise && selected) begin
                // MSB first, held at bit 0 while a one is seen
                shift_reg <= {shift_reg[22:0], pins_sync[0]};
                if (state_reg == ASP_CMD && count_reg == 6'h00 && pins_sync[0]) begin
                    count_reg <= 6'h00;
                end else if (cmd_done || wr_done || rd_done) begin
                    count_reg <= 6'h00;
                end else begin
                    count_reg <= count_reg + 6'h01;
                end
                if (cmd_done) begin
                    rs_reg <= cmd_rs;
                    cread_reg <= shift_reg[`ASP_CREAD_BIT - 1];
                end
            end
        end
    end

    // Ones counter survives deselect so a slow burst still resets
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N || soft_rst) begin
            ones_reg <= 6'h00;
        end else if (sclk_rise && selected) begin
            ones_reg <= pins_sync[0] ? ones_reg + 6'h01 : 6'h00;
        end
    end

    asp_reg_mem u_mem (
        .i_clk(I_CLK),
        .i_reset_n(I_RESET_N && !soft_rst),
        .i_wr_en(wr_done && rs_reg != `ASP_RS_DATA),
        .i_wr_addr(rs_reg),
        .i_wr_data({shift_reg[6:0], pins_sync[0]}),
        // Read ahead on the new field; the old one would return a stale word
        .i_rd_addr(cmd_rs),
        .o_rd_data(mem_rd)
    );

    // Ready flag: set wins over the clear from a data read
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N || soft_rst) begin
            rdy_reg <= 1'b0;
            latched_reg <= 24'h000000;
            sclk_prev_reg <= 1'b1;
        end else begin
            sclk_prev_reg <= pins_sync[2];
            if (I_CONV_VALID) begin
                rdy_reg <= 1'b1;
                latched_reg <= I_CONV_DATA;
            end else if (rd_done && rs_reg == `ASP_RS_DATA) begin
                rdy_reg <= 1'b0;
            end
        end
    end

    // Output shifter: load at the command end, step on falling edges
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N || soft_rst) begin
            out_reg <= 24'hFFFFFF;
        end else if (cmd_done) begin
            if (cmd_rs == `ASP_RS_DATA) begin
                out_reg <= latched_reg;
            end else if (cmd_rs == `ASP_RS_STATUS) begin
                out_reg <= {status_word, 16'h0000};
            end else begin
                out_reg <= {mem_rd, 16'h0000};
            end
        end else if (sclk_fall && selected && state_reg == ASP_RD && count_reg != 6'h00) begin
            out_reg <= {out_reg[22:0], 1'b1};
        end
    end

    // Line shows data during a read, otherwise the inverted ready flag
    always_ff @(posedge I_CLK) begin
        if (!I_RESET_N) begin
            data_reg <= 1'b1;
            oe_reg <= 1'b0;
        end else begin
            data_reg <= (state_reg == ASP_RD) ? out_reg[23] : !rdy_reg;
            oe_reg <= selected;
        end
    end

    assign O_SDO_RDY_N = data_reg;
    assign O_SDO_RDY_OE = oe_reg;
    assign O_STATUS_RDY = rdy_reg;
endmodule : asp_serial_port
`default_nettype wire

// ==== bench/asp_serial_port_properties.sv ====
// Pin-level assertions for the converter serial port
`default_nettype none
module asp_serial_port_properties (
    // Clock, reset and pins
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_SEL_N,
    input wire logic O_SDO_RDY_N,
    input wire logic O_SDO_RDY_OE,
    input wire logic I_CONV_VALID,
    input wire logic O_STATUS_RDY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    // Five clocks cover the three-clock synchroniser lag
    sequence sel_idle;
        I_SEL_N [*5];
    endsequence
    sequence sel_busy;
        !I_SEL_N [*5];
    endsequence
    AST_OE_OFF: assert property (sel_idle |-> !O_SDO_RDY_OE)
        else $error("output driven while idle");
    AST_OE_ON: assert property (sel_busy |-> O_SDO_RDY_OE)
        else $error("output not driven while selected");
    AST_RDY_SET: assert property (I_CONV_VALID |-> ##[1:2] O_STATUS_RDY)
        else $error("ready flag not set");
    AST_RDY_PIN: assert property (I_CONV_VALID |-> ##[1:3] !O_SDO_RDY_N)
        else $error("ready pin did not fall");
    AST_RDY_HOLD: assert property (sel_idle ##0 O_STATUS_RDY |=> O_STATUS_RDY)
        else $error("ready flag lost while idle");
    AST_RDY_CAUSE: assert property ($rose(O_STATUS_RDY) |->
        $past(I_CONV_VALID) || $past(I_CONV_VALID, 2)) else $error("ready without result");
    AST_PIN_IDLE: assert property (sel_idle ##0 !O_STATUS_RDY ##1 !O_STATUS_RDY [*3]
        |-> O_SDO_RDY_N) else $error("ready pin low without result");
    AST_RESET_OUT: assert property (disable iff (1'b0) !I_RESET_N |=>
        O_SDO_RDY_N && !O_SDO_RDY_OE && !O_STATUS_RDY) else $error("bad reset outputs");
endmodule : asp_serial_port_properties
bind asp_serial_port asp_serial_port_properties i_props (.I_CLK, .I_RESET_N, .I_SEL_N,
    .O_SDO_RDY_N, .O_SDO_RDY_OE, .I_CONV_VALID, .O_STATUS_RDY);
`default_nettype wire

// ==== bench/asp_host_model.sv ====
// Host controller model driving the serial pins
`default_nettype none
module asp_host_model (
    // Pins
    input wire logic i_clk,
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_sel_n,
    output logic o_sdi
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sclk = 1'b1; // Stands still between bursts
        o_sel_n = 1'b1;
        o_sdi = 1'b1;
    end
    task automatic sel(input logic v);
        @(negedge i_clk);
        o_sel_n <= v;
        repeat (4) @(negedge i_clk);
    endtask : sel
    // Four clocks a half period; din accumulates so bursts can be split
    task automatic xfer(input int n, input logic [31:0] dout, inout logic [31:0] din);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge i_clk);
            o_sclk <= 1'b0;
            o_sdi <= dout[i];
            repeat (4) @(negedge i_clk);
            o_sclk <= 1'b1;
            din = {din[30:0], i_sdo};
            repeat (3) @(negedge i_clk);
        end
        o_sdi <= ~o_sdi;
    endtask : xfer
endmodule : asp_host_model
`default_nettype wire

// ==== bench/asp_serial_port_bench.sv ====
// Self-checking bench for the converter serial port
`default_nettype none
module asp_serial_port_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic reset_n;
    logic conv_valid;
    logic [23:0] conv_data;
    logic last_sdo = 1'b0;
    logic sclk, sel_n, sdi, sdo, oe, status_rdy;
    logic [31:0] rx;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // Released line shows a changing level, never the last bit
    wire sdo_line = oe ? sdo : ~last_sdo;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        last_sdo <= sdo_line;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            results();
        end
    end
    asp_serial_port i_dut (.I_CLK(clk), .I_RESET_N(reset_n), .I_SCLK(sclk), .I_SEL_N(sel_n),
        .I_SDI(sdi), .O_SDO_RDY_N(sdo), .O_SDO_RDY_OE(oe), .I_CONV_VALID(conv_valid),
        .I_CONV_DATA(conv_data), .O_STATUS_RDY(status_rdy));
    asp_host_model i_host (.i_clk(clk), .i_sdo(sdo_line), .o_sclk(sclk), .o_sel_n(sel_n),
        .o_sdi(sdi));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic post(input logic [23:0] d);
        @(negedge clk);
        conv_valid <= 1'b1;
        conv_data <= d;
        @(negedge clk);
        conv_valid <= 1'b0;
        repeat (3) @(negedge clk);
    endtask : post
    task automatic t_read_result;
        post(24'hA5C3F1);
        check({oe, status_rdy, sdo}, 3'b010);
        i_host.sel(1'b0);
        check(sdo_line, 1'b0);
        i_host.xfer(8, 32'h38, rx);
        i_host.xfer(24, 32'h0, rx);
        check(rx[23:0], 24'hA5C3F1);
        repeat (4) @(negedge clk);
        check({status_rdy, sdo_line}, 2'b01);
        i_host.sel(1'b1);
    endtask : t_read_result
    // Select held low throughout, as on a three-wire bus
    task automatic t_three_wire;
        i_host.sel(1'b0);
        i_host.xfer(16, 32'h105A, rx);
        i_host.xfer(16, 32'h1800, rx);
        check(rx[7:0], 8'h5A);
        i_host.xfer(18, 32'h31800, rx);
        check(rx[7:0], 8'h5A);
        i_host.xfer(12, 32'h080, rx);
        repeat (30) @(negedge clk);
        i_host.xfer(4, 32'h0, rx);
        check(rx[7:0], 8'h88);
    endtask : t_three_wire
    task automatic t_soft_reset;
        post(24'h123456);
        check(status_rdy, 1'b1);
        i_host.xfer(32, 32'hFFFFFFFF, rx);
        repeat (4) @(negedge clk);
        check(status_rdy, 1'b0);
        i_host.xfer(16, 32'h1800, rx);
        check(rx[7:0], 8'h02);
        i_host.sel(1'b1);
        i_host.xfer(16, 32'h10A5, rx);
        i_host.sel(1'b0);
        i_host.xfer(16, 32'h1800, rx);
        check(rx[7:0], 8'h02);
        i_host.sel(1'b1);
    endtask : t_soft_reset
    // Reset pulled in mid-command drops the command and the stored words
    task automatic t_hard_reset;
        i_host.sel(1'b0);
        i_host.xfer(16, 32'h203C, rx);
        i_host.xfer(16, 32'h2800, rx);
        check(rx[7:0], 8'h3C);
        post(24'h0F1E2D);
        i_host.xfer(4, 32'h1, rx);
        @(negedge clk);
        reset_n <= 1'b0;
        repeat (2) @(negedge clk);
        check({oe, status_rdy, sdo}, 3'b001);
        reset_n <= 1'b1;
        repeat (3) @(negedge clk);
        i_host.xfer(16, 32'h2800, rx);
        check(rx[7:0], 8'h00);
        i_host.sel(1'b1);
    endtask : t_hard_reset
    task automatic results;
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    initial begin
        reset_n = 1'b0;
        conv_valid = 1'b0;
        conv_data = 24'h000000;
        repeat (2) @(negedge clk);
        reset_n <= 1'b1;
        repeat (3) @(negedge clk);
        t_read_result();
        t_three_wire();
        t_soft_reset();
        t_hard_reset();
        results();
    end
endmodule : asp_serial_port_bench
`default_nettype wire
